// ===== rtl/srm_block.sv
// SRAM block with flow-through and pipelined read, write port and serial load
`timescale 1ns/1ns
// How it works
// - Flow-through read: data out after one edge
// - Pipelined read: data out after second edge
// - Store word only when store enable active
// - Enables active low unless set active high
// - During write: hold old data or pass written
// - Block reset drives read output low
// - Block reset stops access, keeps contents
// - Each block loadable serially through scan
// - One load carries all 4608 bits
module srm_block (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire srm_pkg::srm_wr_t            wr_req,
  input  wire logic                        rd_en_pin,
  input  wire logic [srm_pkg::AW-1:0]      fetch_location,
  input  wire logic                        blk_reset_n,
  output logic      [srm_pkg::WIDTH-1:0]   rd_data
);

  srm_pkg::srm_ctrl_t          ctrl_r;
  srm_pkg::srm_ctrl_t          ctrl_nxt;
  srm_pkg::srm_scan_t          scan_st_r;
  srm_pkg::srm_scan_t          scan_st_nxt;
  logic [srm_pkg::AW-1:0]      word_idx_r;
  logic [srm_pkg::AW-1:0]      word_idx_nxt;
  logic [3:0]                  sub_r;
  logic [3:0]                  sub_nxt;
  logic [4:0]                  bitpos_r;
  logic [4:0]                  bitpos_nxt;
  logic [31:0]                 shreg_r;
  logic [31:0]                 shreg_nxt;
  logic [srm_pkg::WIDTH-1:0]   asm_r;
  logic [srm_pkg::WIDTH-1:0]   asm_nxt;
  logic [31:0]                 prdata_r;
  logic [31:0]                 prdata_nxt;
  logic                        pready_r;
  logic                        pready_nxt;
  logic                        pslverr_r;
  logic                        pslverr_nxt;
  logic [srm_pkg::WIDTH-1:0]   stage_r;
  logic [srm_pkg::WIDTH-1:0]   stage_nxt;
  logic                        stage_vld_r;
  logic                        stage_vld_nxt;
  logic [srm_pkg::WIDTH-1:0]   rd_data_r;
  logic [srm_pkg::WIDTH-1:0]   rd_data_nxt;

  logic                        apb_pend;
  logic                        apb_acc;
  logic                        stall;
  logic                        mapped;
  logic                        wr_on;
  logic                        rd_on;
  logic                        loading;
  logic                        user_wr;
  logic                        user_rd;
  logic                        scan_we;
  logic                        scan_start;
  logic                        scan_word_in;
  logic                        mem_we;
  logic [srm_pkg::AW-1:0]      mem_waddr;
  logic [srm_pkg::WIDTH-1:0]   mem_wdata;
  logic [srm_pkg::WIDTH-1:0]   arr_rdata;

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign rd_data = rd_data_r;

  // APB: one wait state; a data word for the loader waits while shifting
  assign apb_pend = psel & penable & ~pready_r;
  assign apb_acc  = psel & penable & pready_r;
  assign stall    = pwrite && paddr == srm_pkg::OFF_SCAN_DATA
                    && scan_st_r == srm_pkg::SC_SHIFT;
  assign mapped   = paddr == srm_pkg::OFF_CTRL || paddr == srm_pkg::OFF_STATUS
                    || paddr == srm_pkg::OFF_SCAN_CTRL || paddr == srm_pkg::OFF_SCAN_DATA
                    || paddr == srm_pkg::OFF_RDATA;

  always_comb
  begin
    pready_nxt  = apb_pend & ~stall;
    pslverr_nxt = apb_pend & ~stall & ~mapped;
    prdata_nxt  = prdata_r;
    if (apb_pend && !stall && !pwrite)
    begin
      case (paddr)
        srm_pkg::OFF_CTRL:   prdata_nxt = 32'(ctrl_r);
        srm_pkg::OFF_STATUS: prdata_nxt = 32'({word_idx_r, 1'b0, blk_reset_n,
                                               scan_st_r == srm_pkg::SC_DONE, loading});
        srm_pkg::OFF_RDATA:  prdata_nxt = 32'(rd_data_r);
        default:             prdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt = ctrl_r;
    if (apb_acc && pwrite && paddr == srm_pkg::OFF_CTRL)
    begin
      ctrl_nxt = srm_pkg::srm_ctrl_t'(pwdata[srm_pkg::CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      ctrl_r    <= srm_pkg::CTRL_RESET;
    end
    else
    begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      ctrl_r    <= ctrl_nxt;
    end
  end

  // User ports; both ports share pclk but have separate enables
  assign wr_on   = ctrl_r.wr_high ? wr_req.en : ~wr_req.en;
  assign rd_on   = ctrl_r.rd_high ? rd_en_pin : ~rd_en_pin;
  assign loading = scan_st_r == srm_pkg::SC_ARMED || scan_st_r == srm_pkg::SC_SHIFT;
  assign user_wr = wr_on & blk_reset_n & ~loading;
  assign user_rd = rd_on & blk_reset_n;

  // Loader owns the write port; user writes are refused until it finishes
  assign scan_we   = scan_st_r == srm_pkg::SC_SHIFT && sub_r == srm_pkg::SUB_LAST;
  assign mem_we    = scan_we | user_wr;
  assign mem_waddr = scan_we ? word_idx_r : wr_req.addr;
  assign mem_wdata = scan_we ? {asm_r[srm_pkg::WIDTH-2:0], shreg_r[0]} : wr_req.data;

  srm_array #(
    .DEPTH (srm_pkg::DEPTH),
    .WIDTH (srm_pkg::WIDTH),
    .AW    (srm_pkg::AW)
  ) u_array (
    .clk   (pclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (fetch_location),
    .rdata (arr_rdata)
  );

  // Read path; a read overrides the write output behaviour
  always_comb
  begin
    stage_nxt     = stage_r;
    stage_vld_nxt = 1'b0;
    rd_data_nxt   = rd_data_r;
    if (!blk_reset_n)
    begin
      stage_nxt   = '0;
      rd_data_nxt = '0;
    end
    else if (ctrl_r.pipe_sel)
    begin
      if (user_rd)
      begin
        stage_nxt     = arr_rdata;
        stage_vld_nxt = 1'b1;
      end
      else if (user_wr && ctrl_r.write_output_behaviour)
      begin
        stage_nxt     = wr_req.data;
        stage_vld_nxt = 1'b1;
      end
      if (stage_vld_r)
      begin
        rd_data_nxt = stage_r;
      end
    end
    else
    begin
      if (user_rd)
      begin
        rd_data_nxt = arr_rdata;
      end
      else if (user_wr && ctrl_r.write_output_behaviour)
      begin
        rd_data_nxt = wr_req.data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage_r     <= '0;
      stage_vld_r <= 1'b0;
      rd_data_r   <= '0;
    end
    else
    begin
      stage_r     <= stage_nxt;
      stage_vld_r <= stage_vld_nxt;
      rd_data_r   <= rd_data_nxt;
    end
  end

  // Serial loader: 32-bit words shifted one bit per cycle, nine bits per entry
  assign scan_start   = apb_acc && pwrite && paddr == srm_pkg::OFF_SCAN_CTRL
                        && pwdata[srm_pkg::SCAN_START_POS];
  assign scan_word_in = apb_acc && pwrite && paddr == srm_pkg::OFF_SCAN_DATA;

  always_comb
  begin
    scan_st_nxt  = scan_st_r;
    word_idx_nxt = word_idx_r;
    sub_nxt      = sub_r;
    bitpos_nxt   = bitpos_r;
    shreg_nxt    = shreg_r;
    asm_nxt      = asm_r;
    case (scan_st_r)
      srm_pkg::SC_IDLE, srm_pkg::SC_DONE:
      begin
      end
      srm_pkg::SC_ARMED:
      begin
        if (scan_word_in)
        begin
          shreg_nxt   = pwdata;
          bitpos_nxt  = 5'h00;
          scan_st_nxt = srm_pkg::SC_SHIFT;
        end
      end
      srm_pkg::SC_SHIFT:
      begin
        shreg_nxt  = shreg_r >> 1;
        asm_nxt    = {asm_r[srm_pkg::WIDTH-2:0], shreg_r[0]};
        bitpos_nxt = bitpos_r + 5'h01;
        if (bitpos_r == srm_pkg::BIT_LAST)
          scan_st_nxt = srm_pkg::SC_ARMED;
        if (sub_r == srm_pkg::SUB_LAST)
        begin
          sub_nxt      = 4'h0;
          word_idx_nxt = word_idx_r + 9'h001;
          if (word_idx_r == srm_pkg::WORD_LAST)
            scan_st_nxt = srm_pkg::SC_DONE;
        end
        else
        begin
          sub_nxt = sub_r + 4'h1;
        end
      end
      default: scan_st_nxt = srm_pkg::SC_IDLE;
    endcase
    if (scan_start)
    begin
      scan_st_nxt  = srm_pkg::SC_ARMED;
      word_idx_nxt = '0;
      sub_nxt      = 4'h0;
      asm_nxt      = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scan_st_r  <= srm_pkg::SC_IDLE;
      word_idx_r <= '0;
      sub_r      <= 4'h0;
      bitpos_r   <= 5'h00;
      shreg_r    <= 32'h0000_0000;
      asm_r      <= '0;
    end
    else
    begin
      scan_st_r  <= scan_st_nxt;
      word_idx_r <= word_idx_nxt;
      sub_r      <= sub_nxt;
      bitpos_r   <= bitpos_nxt;
      shreg_r    <= shreg_nxt;
      asm_r      <= asm_nxt;
    end
  end

  sequence s_flow_read;
    user_rd && !ctrl_r.pipe_sel;
  endsequence
  sequence s_pipe_read;
    user_rd && ctrl_r.pipe_sel ##1 blk_reset_n && ctrl_r.pipe_sel;
  endsequence
  sequence s_last_bit;
    scan_st_r == srm_pkg::SC_SHIFT && sub_r == srm_pkg::SUB_LAST
      && word_idx_r == srm_pkg::WORD_LAST && !scan_start;
  endsequence

  AST_FLOW_READ: assert property (@(posedge pclk) disable iff (!presetn)
    s_flow_read |=> rd_data_r == $past(arr_rdata))
    else $error("flow-through read data not on output after one edge");
  AST_PIPE_READ: assert property (@(posedge pclk) disable iff (!presetn)
    s_pipe_read |=> rd_data_r == $past(arr_rdata, 2))
    else $error("pipelined read data not on output after second edge");
  AST_WRITE_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    user_wr && !scan_we |=> u_array.mem_r[$past(wr_req.addr)] == $past(wr_req.data))
    else $error("enabled write did not store the word");
  AST_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_r.wr_high != wr_req.en) |-> !user_wr)
    else $error("write taken with store enable at inactive level");
  AST_WRITE_RETAIN: assert property (@(posedge pclk) disable iff (!presetn)
    user_wr && !user_rd && !ctrl_r.pipe_sel && !ctrl_r.write_output_behaviour
      |=> $stable(rd_data_r))
    else $error("output changed during write with retain behaviour");
  AST_WRITE_PASS: assert property (@(posedge pclk) disable iff (!presetn)
    user_wr && !user_rd && !ctrl_r.pipe_sel && ctrl_r.write_output_behaviour
      |=> rd_data_r == $past(wr_req.data))
    else $error("written data not passed to output");
  AST_RESET_LOW: assert property (@(posedge pclk) disable iff (!presetn)
    !blk_reset_n |=> rd_data_r == '0 && stage_r == '0)
    else $error("block reset did not force output low");
  AST_RESET_NO_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    !blk_reset_n |-> !user_wr && !user_rd)
    else $error("access taken while block reset asserted");
  AST_LOAD_DONE: assert property (@(posedge pclk) disable iff (!presetn)
    s_last_bit |=> scan_st_r == srm_pkg::SC_DONE && word_idx_r == '0)
    else $error("load did not end after the full image");
  AST_PORTS_TOGETHER: assert property (@(posedge pclk) disable iff (!presetn)
    s_flow_read and (user_wr && wr_req.addr != fetch_location)
      |=> rd_data_r == $past(arr_rdata))
    else $error("read disturbed by write to another address");

endmodule // srm_block

// ===== rtl/srm_pkg.sv
// Shared constants, register map and carrier types of the SRAM block
package srm_pkg;

  localparam int unsigned DEPTH      = 512;
  localparam int unsigned WIDTH      = 9;
  localparam int unsigned AW         = 9;
  localparam int unsigned TOTAL_BITS = 4608;
  localparam int unsigned SCAN_WORD  = 32;

  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_STATUS    = 8'h04;
  localparam logic [7:0] OFF_SCAN_CTRL = 8'h08;
  localparam logic [7:0] OFF_SCAN_DATA = 8'h0C;
  localparam logic [7:0] OFF_RDATA     = 8'h10;

  // Control register fields
  localparam int unsigned CTRL_PIPE_POS    = 0;
  localparam int unsigned CTRL_WOB_POS     = 1;
  localparam int unsigned CTRL_WR_HIGH_POS = 2;
  localparam int unsigned CTRL_RD_HIGH_POS = 3;
  localparam int unsigned CTRL_W           = 4;
  localparam logic [3:0]  CTRL_RESET       = 4'h0;

  // Status register fields
  localparam int unsigned ST_BUSY_POS = 0;
  localparam int unsigned ST_DONE_POS = 1;
  localparam int unsigned ST_BLK_POS  = 2;
  localparam int unsigned ST_IDX_LSB  = 4;

  localparam int unsigned SCAN_START_POS = 0;

  localparam logic [AW-1:0] WORD_LAST = 9'h1FF;
  localparam logic [3:0]    SUB_LAST  = 4'h8;
  localparam logic [4:0]    BIT_LAST  = 5'h1F;

  typedef struct packed {
    logic          rd_high;
    logic          wr_high;
    logic          write_output_behaviour;
    logic          pipe_sel;
  } srm_ctrl_t;

  typedef struct packed {
    logic             en;
    logic [AW-1:0]    addr;
    logic [WIDTH-1:0] data;
  } srm_wr_t;

  typedef enum logic [1:0] {
    SC_IDLE  = 2'b00,
    SC_ARMED = 2'b01,
    SC_SHIFT = 2'b11,
    SC_DONE  = 2'b10
  } srm_scan_t;

endpackage

// ===== rtl/srm_array.sv
// Flip-flop storage array: one write port, one combinational read port
`timescale 1ns/1ns
module srm_array #(
  parameter int unsigned DEPTH = srm_pkg::DEPTH,
  parameter int unsigned WIDTH = srm_pkg::WIDTH,
  parameter int unsigned AW    = srm_pkg::AW
) (
  input  wire logic             clk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  if (DEPTH < 2 || WIDTH < 1 || (64'd1 << AW) < 64'(DEPTH))
  begin : g_bad_size
    $error("srm_array: DEPTH, WIDTH or AW out of range");
  end

  assign rdata = mem_r[raddr];

  // Contents have no reset: block reset must leave them untouched
  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

endmodule // srm_array

// ===== testbench/srm_user_model.sv
// Behavioural user logic that drives the block's read and write ports
`timescale 1ns/1ns
module srm_user_model (
  input  wire logic                      pclk,
  input  wire logic [srm_pkg::WIDTH-1:0] rd_data,
  output srm_pkg::srm_wr_t               wr_req,
  output logic                           rd_en_pin,
  output logic [srm_pkg::AW-1:0]         fetch_location,
  output logic                           blk_reset_n
);
  logic wr_hi = 1'b0;
  logic rd_hi = 1'b0;

  initial
  begin
    wr_req         = {1'b1, 9'h000, 9'h000};
    rd_en_pin      = 1'b1;
    fetch_location = 9'h000;
    blk_reset_n    = 1'b1;
  end

  // One cycle with an optional read and an optional write on the same edge
  task automatic op(input logic rd, input logic [8:0] ra, input logic wr,
                    input logic [8:0] wa, input logic [8:0] wd,
                    output logic [8:0] d1, output logic [8:0] d2);
    @(posedge pclk);
    rd_en_pin      <= rd ~^ rd_hi;
    wr_req         <= '{en: wr ~^ wr_hi, addr: wa, data: wd};
    fetch_location <= ra;
    @(posedge pclk);
    rd_en_pin      <= ~rd_hi;
    wr_req.en      <= ~wr_hi;
    #1 d1 = rd_data;
    @(posedge pclk);
    #1 d2 = rd_data;
  endtask

  // Enables must move to the new idle level together with the polarity
  task automatic set_pol(input logic w, input logic r);
    @(posedge pclk);
    wr_hi     <= w;
    rd_hi     <= r;
    wr_req.en <= ~w;
    rd_en_pin <= ~r;
  endtask

  task automatic set_blk(input logic v);
    @(posedge pclk);
    blk_reset_n <= v;
  endtask
endmodule // srm_user_model

// ===== testbench/tb_top.sv
// Self-checking testbench of the SRAM block
`timescale 1ns/1ns
module tb_top;
  logic                      pclk = 1'b0;
  logic                      presetn = 1'b0;
  logic                      psel = 1'b0;
  logic                      penable = 1'b0;
  logic                      pwrite = 1'b0;
  logic [7:0]                paddr = 8'h00;
  logic [31:0]               pwdata = 32'h0000_0000;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  srm_pkg::srm_wr_t          wr_req;
  logic                      rd_en_pin;
  logic [srm_pkg::AW-1:0]    fetch_location;
  logic                      blk_reset_n;
  logic [srm_pkg::WIDTH-1:0] rd_data;
  logic [31:0]               rv;
  logic                      er;
  logic [8:0]                d1;
  logic [8:0]                d2;
  int                        err_count = 0;
  int                        comparisons = 0;

  always #25 pclk = ~pclk;

  srm_block dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wr_req(wr_req), .rd_en_pin(rd_en_pin),
    .fetch_location(fetch_location), .blk_reset_n(blk_reset_n), .rd_data(rd_data));

  srm_user_model u_user (.pclk(pclk), .rd_data(rd_data), .wr_req(wr_req),
    .rd_en_pin(rd_en_pin), .fetch_location(fetch_location), .blk_reset_n(blk_reset_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Request is held until pready is seen high; no latency is assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] lw(int k);
    return {k[7:0], ~k[7:0], 8'h5A, k[7:0] ^ 8'hC3};
  endfunction

  // First bit shifted in becomes the entry's top bit
  function automatic logic [8:0] le(int e);
    logic [31:0] w;
    le = 9'h000;
    for (int j = 0; j < 9; j++)
    begin
      w = lw((9 * e + j) / 32);
      le[8 - j] = w[(9 * e + j) % 32];
    end
  endfunction

  task automatic s_regs();
    apb(1'b0, srm_pkg::OFF_CTRL, 32'h0000_0000);
    chk(rv, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({31'h0, er}, 32'h0000_0001);
    chk(rv, 32'h0000_0000);
  endtask

  task automatic s_load();
    int ent[4] = '{0, 1, 255, 511};
    apb(1'b1, srm_pkg::OFF_SCAN_CTRL, 32'h0000_0001);
    for (int k = 0; k < 144; k++)
      apb(1'b1, srm_pkg::OFF_SCAN_DATA, lw(k));
    // The last word still shifts for 32 cycles after its write is accepted
    do
      apb(1'b0, srm_pkg::OFF_STATUS, 32'h0000_0000);
    while (rv[0] !== 1'b0);
    chk({30'h0, rv[1:0]}, 32'h0000_0002);
    foreach (ent[i])
    begin
      u_user.op(1'b1, 9'(ent[i]), 1'b0, 9'h000, 9'h000, d1, d2);
      chk(32'(d1), 32'(le(ent[i])));
    end
  endtask

  task automatic s_user();
    u_user.op(1'b0, 9'h000, 1'b1, 9'h005, 9'h1A5, d1, d2);
    u_user.op(1'b0, 9'h000, 1'b0, 9'h006, 9'h0F0, d1, d2);
    u_user.op(1'b1, 9'h005, 1'b0, 9'h000, 9'h000, d1, d2);
    chk(32'(d1), 32'h0000_01A5);
    u_user.op(1'b1, 9'h006, 1'b0, 9'h000, 9'h000, d1, d2);
    chk(32'(d1), 32'(le(6)));
    u_user.op(1'b1, 9'h005, 1'b1, 9'h009, 9'h111, d1, d2);
    chk(32'(d1), 32'h0000_01A5);
    u_user.op(1'b1, 9'h009, 1'b0, 9'h000, 9'h000, d1, d2);
    chk(32'(d1), 32'h0000_0111);
  endtask

  task automatic s_modes();
    u_user.op(1'b0, 9'h000, 1'b1, 9'h00A, 9'h0F0, d1, d2);
    chk(32'(d1), 32'h0000_0111);
    apb(1'b1, srm_pkg::OFF_CTRL, 32'h0000_0002);
    u_user.op(1'b0, 9'h000, 1'b1, 9'h00B, 9'h133, d1, d2);
    chk(32'(d1), 32'h0000_0133);
    apb(1'b1, srm_pkg::OFF_CTRL, 32'h0000_0001);
    u_user.op(1'b1, 9'h005, 1'b0, 9'h000, 9'h000, d1, d2);
    chk(32'(d1), 32'h0000_0133);
    chk(32'(d2), 32'h0000_01A5);
    apb(1'b0, srm_pkg::OFF_RDATA, 32'h0000_0000);
    chk(rv, 32'h0000_01A5);
    apb(1'b1, srm_pkg::OFF_CTRL, 32'h0000_0003);
    u_user.op(1'b0, 9'h000, 1'b1, 9'h00E, 9'h155, d1, d2);
    chk(32'(d1), 32'h0000_01A5);
    chk(32'(d2), 32'h0000_0155);
  endtask

  // Polarity is switched under block reset so no stray access slips in
  task automatic s_blk();
    for (int m = 0; m < 2; m++)
    begin
      if (m == 1)
        apb(1'b1, srm_pkg::OFF_CTRL, 32'h0000_000D);
      u_user.set_blk(1'b0);
      @(posedge pclk);
      #1 chk(32'(rd_data), 32'h0000_0000);
      apb(1'b0, srm_pkg::OFF_STATUS, 32'h0000_0000);
      chk(32'(rv[2]), 32'h0000_0000);
      apb(1'b1, srm_pkg::OFF_CTRL, 32'h0000_000C | 32'(m));
      u_user.set_pol(1'b1, 1'b1);
      u_user.op(1'b0, 9'h000, 1'b1, 9'h005, 9'h0AA, d1, d2);
      u_user.set_blk(1'b1);
      u_user.op(1'b1, 9'h005, 1'b0, 9'h000, 9'h000, d1, d2);
      chk(32'(m ? d2 : d1), 32'h0000_01A5);
      u_user.op(1'b0, 9'h000, 1'b1, 9'(12 + m), 9'(9'h0C3 + m), d1, d2);
      u_user.op(1'b1, 9'(12 + m), 1'b0, 9'h000, 9'h000, d1, d2);
      chk(32'(m ? d2 : d1), 32'(9'h0C3 + m));
    end
  endtask

  initial
  begin
    #(50 * 40000);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_load();
    s_user();
    s_modes();
    s_blk();
    finish_test();
  end
endmodule // tb_top
